//--- audio_dynamic_range_gain.v
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

`include "level_compressor_defs.vh"

module audio_dynamic_range_gain #(
  parameter DATA_W    = 24,
  parameter AVG_SHIFT = 8
) (
  input  wire                 clk_sys,
  input  wire                 reset_n,
  input  wire [`ADDR_W-1:0]   awaddr,
  input  wire                 awvalid,
  output reg                  awready,
  input  wire [31:0]          wdata,
  input  wire [3:0]           wstrb,
  input  wire                 wvalid,
  output reg                  wready,
  output reg  [1:0]           bresp,
  output reg                  bvalid,
  input  wire                 bready,
  input  wire [`ADDR_W-1:0]   araddr,
  input  wire                 arvalid,
  output reg                  arready,
  output reg  [31:0]          rdata,
  output reg  [1:0]           rresp,
  output reg                  rvalid,
  input  wire                 rready,
  input  wire [DATA_W-1:0]    adcIn,
  input  wire                 adcInValid,
  input  wire [DATA_W-1:0]    dacIn,
  input  wire                 dacInValid,
  output reg  [DATA_W-1:0]    adcOut,
  output reg                  adcOutValid,
  output reg  [DATA_W-1:0]    dacOut,
  output reg                  dacOutValid
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // address to register number; 3'h7 is unmapped
  function [2:0] regSel;
    input [`ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0)
        regSel = 3'h7;
      else if (a[`ADDR_W-1:2] == {2'h0, `CTRL0_IDX})
        regSel = 3'h0;
      else if (a[`ADDR_W-1:2] == {2'h0, `CTRL1_IDX})
        regSel = 3'h1;
      else if (a[`ADDR_W-1:2] == {2'h0, `CTRL2_IDX})
        regSel = 3'h2;
      else if (a[`ADDR_W-1:2] == {2'h0, `CTRL3_IDX})
        regSel = 3'h3;
      else if (a[`ADDR_W-1:2] == {2'h0, `STATUS_IDX})
        regSel = 3'h4;
      else
        regSel = 3'h7;
    end
  endfunction

  function [15:0] laneMerge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      laneMerge[7:0]  = s[0] ? d[7:0]  : old[7:0];
      laneMerge[15:8] = s[1] ? d[15:8] : old[15:8];
    end
  endfunction

  // scale a level difference by a slope code
  function [13:0] slopeScale;
    input [13:0] d;
    input [2:0]  code;
    input        upper;
    reg   [2:0]  c;
    begin
      c = code;
      if (upper && c > `USL_ZERO)
        c = `USL_ZERO;
      if (!upper && c > `LSL_ZERO)
        c = `LSL_ZERO;
      if ((upper && c == `USL_ZERO) || (!upper && c == `LSL_ZERO))
        slopeScale = 14'h0000;
      else
        slopeScale = d >> c;
    end
  endfunction

  // steady-state gain for an input level, 1/16 of 0.75 dB units
  function [13:0] staticGain;
    input [7:0] att;
    input [5:0] kin;
    input [4:0] kout;
    input [2:0] usl;
    input [2:0] lsl;
    reg   [5:0] kc;
    reg   [4:0] oc;
    reg   [13:0] a;
    reg   [13:0] k;
    reg   [13:0] o;
    reg   [13:0] y;
    begin
      kc = (kin > `KIN_MAX) ? `KIN_MAX : kin;
      oc = (kout > `KOUT_MAX) ? `KOUT_MAX : kout;
      a  = {2'h0, att, `FRAC_ZERO};
      k  = {4'h0, kc, `FRAC_ZERO};
      o  = {5'h00, oc, `FRAC_ZERO};
      if (a <= k)
        y = o - slopeScale(k - a, usl, 1'b1);
      else
        y = o + slopeScale(a - k, lsl, 1'b0);
      staticGain = a - y;
    end
  endfunction

  function [13:0] floorGain;
    input [1:0] c;
    begin
      case (c)
        2'h0:    floorGain = `FLOOR_0;
        2'h1:    floorGain = `FLOOR_1;
        2'h2:    floorGain = `FLOOR_2;
        default: floorGain = `FLOOR_3;
      endcase
    end
  endfunction

  function [13:0] ceilGain;
    input [1:0] c;
    begin
      case (c)
        2'h0:    ceilGain = `CEIL_0;
        2'h1:    ceilGain = `CEIL_1;
        2'h2:    ceilGain = `CEIL_2;
        default: ceilGain = `CEIL_3;
      endcase
    end
  endfunction

  // dB gain to linear multiply with saturation
  function [DATA_W-1:0] applyGain;
    input [DATA_W-1:0] s;
    input [13:0]       g;
    reg   [13:0]       e;
    reg   [13:0]       sh;
    reg signed [DATA_W+9:0]  p;
    reg signed [DATA_W+16:0] w;
    begin
      e  = {{`OCT_SH{g[13]}}, g[13:`OCT_SH]};
      sh = 14'h0007 - e;
      p  = $signed(s) * $signed({3'h1, g[`OCT_SH-1:0]});
      w  = {{7{p[DATA_W+9]}}, p};
      w  = w >>> sh[3:0];
      if (&w[DATA_W+16:DATA_W-1] || ~|w[DATA_W+16:DATA_W-1])
        applyGain = w[DATA_W-1:0];
      else
        applyGain = w[DATA_W+16] ? {1'b1, {(DATA_W-1){1'b0}}}
                                 : {1'b0, {(DATA_W-1){1'b1}}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // control registers

  reg         on_q;
  reg         path_q;
  reg  [1:0]  floor_q;
  reg  [1:0]  ceil_q;
  reg  [2:0]  usl_q;
  reg  [2:0]  lsl_q;
  reg  [5:0]  kin_q;
  reg  [4:0]  kout_q;
  reg  [13:0] gain_q;
  reg  [13:0] fullScale_q;

  wire [15:0] ctrl0 = {on_q, path_q, 14'h0000};
  wire [15:0] ctrl1 = {12'h000, floor_q, ceil_q};
  wire [15:0] ctrl2 = {10'h000, usl_q, lsl_q};
  wire [15:0] ctrl3 = {5'h00, kin_q, kout_q};
  wire [31:0] status = {2'h0, fullScale_q, 2'h0, gain_q};

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side

  reg  [`ADDR_W-1:0] awAddr_q;
  reg                awHeld_q;
  reg  [31:0]        wData_q;
  reg  [3:0]         wStrb_q;
  reg                wHeld_q;

  wire       doWrite = awHeld_q & wHeld_q & ~bvalid;
  wire [2:0] wSel    = regSel(awAddr_q);
  wire [15:0] new0   = laneMerge(ctrl0, wData_q, wStrb_q);
  wire [15:0] new1   = laneMerge(ctrl1, wData_q, wStrb_q);
  wire [15:0] new2   = laneMerge(ctrl2, wData_q, wStrb_q);
  wire [15:0] new3   = laneMerge(ctrl3, wData_q, wStrb_q);

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= {`ADDR_W{1'b0}};
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      on_q     <= `ON_RST;
      path_q   <= `PATH_RST;
      floor_q  <= `FLOOR_RST;
      ceil_q   <= `CEIL_RST;
      usl_q    <= `USL_RST;
      lsl_q    <= `LSL_RST;
      kin_q    <= `KIN_RST;
      kout_q   <= `KOUT_RST;
    end else begin
      if (awvalid && awready) begin
        awAddr_q <= awaddr;
        awHeld_q <= 1'b1;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wHeld_q <= 1'b1;
        wready  <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (wSel > 3'h3) ? `RESP_SLVERR : `RESP_OKAY;
        case (wSel)
          3'h0: begin
            on_q   <= new0[`ON_BIT];
            path_q <= new0[`PATH_BIT];
          end
          3'h1: begin
            floor_q <= new1[`FLOOR_HI:`FLOOR_LO];
            ceil_q  <= new1[`CEIL_HI:`CEIL_LO];
          end
          3'h2: begin
            usl_q <= new2[`USL_HI:`USL_LO];
            lsl_q <= new2[`LSL_HI:`LSL_LO];
          end
          3'h3: begin
            kin_q  <= new3[`KIN_HI:`KIN_LO];
            kout_q <= new3[`KOUT_HI:`KOUT_LO];
          end
          default: begin
          end
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side

  wire [2:0] rSel = regSel(araddr);

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= (rSel == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
        case (rSel)
          3'h0:    rdata <= {16'h0000, ctrl0};
          3'h1:    rdata <= {16'h0000, ctrl1};
          3'h2:    rdata <= {16'h0000, ctrl2};
          3'h3:    rdata <= {16'h0000, ctrl3};
          3'h4:    rdata <= status;
          default: rdata <= 32'h00000000;
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // level estimate and gain computer

  // only the selected path feeds the estimator
  wire [DATA_W-1:0] selIn      = path_q ? dacIn : adcIn;
  wire              selInValid = path_q ? dacInValid : adcInValid;
  wire [7:0]        levelAtt;

  level_estimator #(
    .DATA_W    (DATA_W),
    .AVG_SHIFT (AVG_SHIFT)
  ) u_level (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .sample      (selIn),
    .sampleValid (selInValid),
    .levelAtt    (levelAtt)
  );

  wire [13:0] rawGain = staticGain(levelAtt, kin_q, kout_q,
                                   usl_q, lsl_q);
  wire [13:0] lowGain = floorGain(floor_q);
  wire [13:0] highGain = ceilGain(ceil_q);

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      gain_q      <= 14'h0000;
      fullScale_q <= 14'h0000;
    end else begin
      // output level at 0 dB input
      fullScale_q <= staticGain(8'h00, kin_q, kout_q,
                                usl_q, lsl_q);
      if ($signed(rawGain) < $signed(lowGain))
        gain_q <= lowGain;
      else if ($signed(rawGain) > $signed(highGain))
        gain_q <= highGain;
      else
        gain_q <= rawGain;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sample paths

  wire [DATA_W-1:0] adcGained = applyGain(adcIn, gain_q);
  wire [DATA_W-1:0] dacGained = applyGain(dacIn, gain_q);
  wire              onAdc     = on_q & ~path_q;
  wire              onDac     = on_q & path_q;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      adcOut      <= {DATA_W{1'b0}};
      adcOutValid <= 1'b0;
      dacOut      <= {DATA_W{1'b0}};
      dacOutValid <= 1'b0;
    end else begin
      adcOutValid <= adcInValid;
      dacOutValid <= dacInValid;
      if (adcInValid)
        adcOut <= onAdc ? adcGained : adcIn;
      if (dacInValid)
        dacOut <= onDac ? dacGained : dacIn;
    end
  end

endmodule

`default_nettype wire

//--- level_compressor_defs.vh
`ifndef LEVEL_COMPRESSOR_DEFS_VH
`define LEVEL_COMPRESSOR_DEFS_VH

// register indices; byte address is four times the index
`define CTRL0_IDX   8'h28
`define CTRL1_IDX   8'h29
`define CTRL2_IDX   8'h2a
`define CTRL3_IDX   8'h2b
`define STATUS_IDX  8'h2c
`define ADDR_W      12

// control 0
`define ON_BIT      15
`define PATH_BIT    14
`define ON_RST      1'b0
`define PATH_RST    1'b0
// control 1
`define FLOOR_HI    3
`define FLOOR_LO    2
`define CEIL_HI     1
`define CEIL_LO     0
`define FLOOR_RST   2'h2
`define CEIL_RST    2'h0
// control 2
`define USL_HI      5
`define USL_LO      3
`define LSL_HI      2
`define LSL_LO      0
`define USL_RST     3'h0
`define LSL_RST     3'h0
`define USL_ZERO    3'h5
`define LSL_ZERO    3'h4
// control 3
`define KIN_HI      10
`define KIN_LO      5
`define KOUT_HI     4
`define KOUT_LO     0
`define KIN_RST     6'h00
`define KOUT_RST    5'h00
`define KIN_MAX     6'h3c
`define KOUT_MAX    5'h1e
// status
`define FS_LO       16
`define GAIN_LO     0

// gain limits, 1/16 of a 0.75 dB step
`define FLOOR_0     14'h0000
`define FLOOR_1     14'h3f80
`define FLOOR_2     14'h3f00
`define FLOOR_3     14'h3e80
`define CEIL_0      14'h0100
`define CEIL_1      14'h0180
`define CEIL_2      14'h0200
`define CEIL_3      14'h0300

// one octave of gain is 128 such units
`define OCT_SH      7
`define FRAC_ZERO   4'h0
`define LEVEL_MAX   8'h7f
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

//--- level_estimator.v
`timescale 1ns/10ps
`default_nettype none

`include "level_compressor_defs.vh"

module level_estimator #(
  parameter DATA_W    = 24,
  parameter AVG_SHIFT = 8
) (
  input  wire              clk_sys,
  input  wire              reset_n,
  input  wire [DATA_W-1:0] sample,
  input  wire              sampleValid,
  output reg  [7:0]        levelAtt
);

  function [5:0] topBit;
    input [31:0] v;
    integer i;
    begin
      topBit = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (v[i])
          topBit = i[5:0];
      end
    end
  endfunction

  wire [15:0] top16 = sample[DATA_W-1:DATA_W-16];
  wire [15:0] mag   = top16[15] ? (~top16 + 16'h0001) : top16;
  wire [31:0] sq    = mag * mag;

  reg  [31:0] ms_q;
  wire [5:0]  lz    = 6'h1f - topBit(ms_q);
  wire [31:0] norm  = ms_q << lz;
  // 3 dB per bit of mean square, four steps of 0.75 dB
  wire [8:0]  raw   = {1'b0, lz, 2'b00} - {7'h00, norm[30:29]}
                      - 9'h004;

  // mean square averaged over time, not per sample
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ms_q     <= 32'h00000000;
      levelAtt <= `LEVEL_MAX;
    end else begin
      if (sampleValid)
        ms_q <= ms_q + (sq >> AVG_SHIFT) - (ms_q >> AVG_SHIFT);
      if (ms_q == 32'h00000000 || (!raw[8] && raw[7:0] > `LEVEL_MAX))
        levelAtt <= `LEVEL_MAX;
      else if (raw[8])
        levelAtt <= 8'h00;
      else
        levelAtt <= raw[7:0];
    end
  end

endmodule

`default_nettype wire

//--- sample_source.sv
`timescale 1ns/10ps
`default_nettype none
module sample_source #(
  parameter int DATA_W = 24
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [DATA_W-1:0] amp,
  output var  logic [DATA_W-1:0] sample,
  output var  logic              valid
);
  logic neg_q;
  ////////////////////////////////////////
  // square wave, one sample every other cycle; line scrambled between
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      valid  <= 1'b0;
      neg_q  <= 1'b0;
      sample <= '0;
    end else begin
      valid <= ~valid;
      if (!valid) begin
        neg_q  <= ~neg_q;
        sample <= neg_q ? -amp : amp;
      end else begin
        sample <= ~sample;
      end
    end
  end
endmodule
`default_nettype wire

//--- audio_dynamic_range_gain_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "level_compressor_defs.vh"
module audio_dynamic_range_gain_assertions #(
  parameter DATA_W    = 24,
  parameter AVG_SHIFT = 8
) (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic [31:0]        wdata,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire logic [1:0]         bresp,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [31:0]        rdata,
  input wire logic [1:0]         rresp,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [DATA_W-1:0]  adcIn,
  input wire logic               adcInValid,
  input wire logic [DATA_W-1:0]  dacIn,
  input wire logic               dacInValid,
  input wire logic [DATA_W-1:0]  adcOut,
  input wire logic               adcOutValid,
  input wire logic [DATA_W-1:0]  dacOut,
  input wire logic               dacOutValid
);
  logic [`ADDR_W-1:0] rdAddr_q;
  logic               on_q;
  logic               path_q;
  logic [1:0]         floor_q;
  logic [1:0]         ceil_q;
  int                 gain;
  int                 lo;
  int                 hi;
  assign gain = $signed(rdata[13:0]);
  assign lo   = -128 * floor_q;
  assign hi   = (ceil_q == 2'h3) ? 768 : 256 + 128 * ceil_q;
  ////////////////////////////////////////
  // shadow of the enable, path and limit fields
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      on_q    <= `ON_RST;
      path_q  <= `PATH_RST;
      floor_q <= `FLOOR_RST;
      ceil_q  <= `CEIL_RST;
      rdAddr_q <= '0;
    end else begin
      if (arvalid && arready) rdAddr_q <= araddr;
      if (awvalid && awready && wvalid && wready) begin
        if (awaddr == 12'ha0) begin
          on_q   <= wdata[`ON_BIT];
          path_q <= wdata[`PATH_BIT];
        end
        if (awaddr == 12'ha4) begin
          floor_q <= wdata[`FLOOR_HI:`FLOOR_LO];
          ceil_q  <= wdata[`CEIL_HI:`CEIL_LO];
        end
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence wrTake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTake;
    arvalid && arready;
  endsequence
  AST_WR_ANSWER: assert property (wrTake |-> ##2 bvalid)
    else $error("write response late");
  AST_WR_BUSY: assert property (wrTake |=> (!awready && !wready) [*2])
    else $error("write channels ready too early");
  AST_RD_ANSWER: assert property (rdTake |=> rvalid && !arready)
    else $error("read response late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_RD_REFUSE: assert property (rvalid && !(rdAddr_q inside {12'ha0,
    12'ha4, 12'ha8, 12'hac, 12'hb0}) |-> rresp == `RESP_SLVERR && rdata == 0)
    else $error("unmapped read not refused");
  AST_ADC_LATENCY: assert property (
    1'b1 |=> adcOutValid == $past(adcInValid))
    else $error("adc output valid misplaced");
  AST_DAC_LATENCY: assert property (
    1'b1 |=> dacOutValid == $past(dacInValid))
    else $error("dac output valid misplaced");
  AST_ADC_PASS: assert property (
    adcInValid && awready && (!on_q || path_q) |=> adcOut == $past(adcIn))
    else $error("adc sample altered");
  AST_DAC_PASS: assert property (
    dacInValid && awready && (!on_q || !path_q) |=> dacOut == $past(dacIn))
    else $error("dac sample altered");
  AST_GAIN_BOUND: assert property (rvalid && rdAddr_q == 12'hb0 |->
    gain >= lo && gain <= hi)
    else $error("gain outside limits");
endmodule
bind audio_dynamic_range_gain audio_dynamic_range_gain_assertions #(
  .DATA_W   (DATA_W),
  .AVG_SHIFT(AVG_SHIFT)
) chk (.*);
`default_nettype wire

//--- audio_dynamic_range_gain_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "level_compressor_defs.vh"
module audio_dynamic_range_gain_tb;
  localparam int DW = 24;
  logic          clk_sys, reset_n;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata, d;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, r;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic [DW-1:0] adcIn, dacIn, adcOut, dacOut, adcAmp, dacAmp;
  logic          adcInValid, dacInValid, adcOutValid, dacOutValid;
  int            fails, comparisons, k, o, u, y;
  int            kin[5] = '{8, 60, 16, 4, 63};
  int            kout[5] = '{2, 30, 4, 0, 31};
  int            usl[5] = '{1, 4, 5, 0, 7};
  audio_dynamic_range_gain #(.DATA_W(DW), .AVG_SHIFT(2)) dut (.*);
  sample_source #(.DATA_W(DW)) adcSrc (.*, .amp(adcAmp), .sample(adcIn),
    .valid(adcInValid));
  sample_source #(.DATA_W(DW)) dacSrc (.*, .amp(dacAmp), .sample(dacIn),
    .valid(dacInValid));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] handshake expected 1 seen 0");
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 64);
    hang(bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] e);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 64);
    hang(rvalid);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] exp, input logic [1:0] er);
    rd(a, d, r);
    chk(nm, exp, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic pass_chk(input logic dac, input int sh);
    logic [DW-1:0] s;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(dac ? dacInValid : adcInValid) && n < 8);
    hang(dac ? dacInValid : adcInValid);
    // expected output is the taken sample scaled by 2 to the minus sh
    s = $signed(dac ? dacIn : adcIn) >>> sh;
    @(posedge clk_sys);
    chk(dac ? "dacOut" : "adcOut", 32'(s), 32'(dac ? dacOut : adcOut));
  endtask
  task automatic gcase(input logic [DW-1:0] amp, input logic [31:0] c1, c2,
                       c3, input int exp);
    adcAmp <= amp;
    wr(12'ha4, c1, `RESP_OKAY);
    wr(12'ha8, c2, `RESP_OKAY);
    wr(12'hac, c3, `RESP_OKAY);
    repeat (100) @(posedge clk_sys);
    rd(12'hb0, d, r);
    chk("gain", {18'h0, exp[13:0]}, {18'h0, d[13:0]});
  endtask
  ////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb  = 4'hf;
    adcAmp = 24'h123456;
    dacAmp = 24'h0abcde;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc("ctrl0", 12'ha0, 32'h0, `RESP_OKAY);
    rc("ctrl1", 12'ha4, 32'h8, `RESP_OKAY);
    rc("ctrl2", 12'ha8, 32'h0, `RESP_OKAY);
    rc("ctrl3", 12'hac, 32'h0, `RESP_OKAY);
    rc("unmapped", 12'hb4, 32'h0, `RESP_SLVERR);
    $display("test reset done");
    wr(12'ha8, 32'hffffffff, `RESP_OKAY);
    rc("ctrl2", 12'ha8, 32'h3f, `RESP_OKAY);
    wr(12'hb0, 32'h1, `RESP_SLVERR);
    wr(12'ha2, 32'h1, `RESP_SLVERR);
    $display("test access done");
    for (int i = 0; i < 5; i++) begin
      k = (kin[i] > 60) ? 60 : kin[i];
      o = (kout[i] > 30) ? 30 : kout[i];
      u = (usl[i] > 5) ? 5 : usl[i];
      y = -16 * o + ((u == 5) ? 0 : ((16 * k) >>> u));
      wr(12'ha8, usl[i] << 3, `RESP_OKAY);
      wr(12'hac, (kin[i] << 5) | kout[i], `RESP_OKAY);
      rd(12'hb0, d, r);
      chk("fullScale", {18'h0, y[13:0]}, {18'h0, d[29:16]});
    end
    $display("test full scale done");
    for (int i = 0; i < 3; i++) begin
      wr(12'ha0, (i == 0) ? 32'h0 : (i == 1) ? 32'h8000 : 32'hc000, 2'h0);
      if (i != 1) pass_chk(1'b0, 0);
      if (i != 2) pass_chk(1'b1, 0);
    end
    rc("ctrl0", 12'ha0, 32'hc000, `RESP_OKAY);
    $display("test path done");
    wr(12'ha0, 32'h8000, `RESP_OKAY);
    for (int i = 0; i < 4; i++)
      gcase('0, 32'hc | i, 32'h4, 32'h102,
            (i == 3) ? 768 : 256 + 128 * i);
    gcase('0, 32'hf, 32'h0, 32'h102, 96);
    for (int i = 0; i < 4; i++) begin
      gcase(24'h7fffff, (i << 2) | 3, 32'h28, 32'h1e,
            -128 * i);
      pass_chk(1'b0, i);
    end
    $display("test gain done");
    close_out();
  end
endmodule
`default_nettype wire
